// file: rtl/rtc_pkg.sv
// constants, types and register map of the real-time clock block
// What this block does
// - each 1 Hz tick with enable bit 7 set advances seconds and sets the per-second flag, bit 4
// - seconds wrapping 59 to 00 advances minutes and sets minute flag, bit 1
// - every hours advance from a minutes wrap sets the hourly flag, bit 5
// - hours wrapping 23 to 00 advances the 16-bit day counter, sets bit 3
// - a cleared enable only blocks the interrupt; status flags still set
// - enable register mirrors status layout, bits 5 to 0, reset to zero
// - full day/hour/minute/second alarm match sets alarm flag bit 2
// - alarm recurs every 65536 days; software clears enable for one shot
// - stopwatch count decrements by one on each minute tick until it reaches -1
// - count reaching -1 sets stopwatch flag bit 0 and holds at -1
// - enabling stopwatch while count is -1 posts it at next minute tick
// - stopwatch count is 6-bit field 5..0, resets to all ones, rest zero
// - day counter and day alarm are 16-bit read/write fields
// - a write to a time counter replaces the count; counting continues
// - 32-bit divisor split: upper register 31:16, lower register 15:0
// - 1 Hz tick is reference clock divided by full divisor
// - sampling clock is reference clock divided by divisor bits 31:9
// - a zero divisor stops the 1 Hz tick and all counting
// - writing 1 clears a status flag; writing 0 leaves it
// - soft reset bit restores defaults; enable bit 7 takes the value written with it
// - hours count 0..23 in bits 12..8; minutes and seconds 0..59
package rtc_pkg;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [11:0] OFS_HOUR_MINUTE  = 12'h3C0;
    localparam logic [11:0] OFS_SECONDS      = 12'h3C4;
    localparam logic [11:0] OFS_ALARM_HM     = 12'h3C8;
    localparam logic [11:0] OFS_ALARM_SEC    = 12'h3CC;
    localparam logic [11:0] OFS_CONTROL      = 12'h3D0;
    localparam logic [11:0] OFS_EVENT_STATUS = 12'h3D4;
    localparam logic [11:0] OFS_EVENT_ENABLE = 12'h3D8;
    localparam logic [11:0] OFS_STOPWATCH    = 12'h3DC;
    localparam logic [11:0] OFS_DAY_COUNTER  = 12'h3E0;
    localparam logic [11:0] OFS_DAY_ALARM    = 12'h3E4;
    localparam logic [11:0] OFS_DIV_UPPER    = 12'h3F4;
    localparam logic [11:0] OFS_DIV_LOWER    = 12'h3F8;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int          BIT_HOURLY     = 5;
    localparam int          BIT_SECOND     = 4;
    localparam int          BIT_DAY        = 3;
    localparam int          BIT_ALARM      = 2;
    localparam int          BIT_MINUTE     = 1;
    localparam int          BIT_STOPWATCH  = 0;
    localparam int          BIT_ENABLE     = 7;
    localparam int          BIT_SOFT_RESET = 0;
    localparam int          HOURS_LSB      = 8;
    localparam logic [5:0]  LAST_SECOND    = 6'h3B;
    localparam logic [5:0]  LAST_MINUTE    = 6'h3B;
    localparam logic [4:0]  LAST_HOUR      = 5'h17;
    localparam logic [5:0]  STOPWATCH_RST  = 6'h3F;
    localparam logic [5:0]  STOPWATCH_DONE = 6'h3F;
    localparam logic        ENABLE_RST     = 1'h1;
    localparam logic [31:0] DIVISOR_RST    = 32'h0000_8000;
    localparam int          SAMPLE_SHIFT   = 9;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic [15:0] day;
        logic [4:0]  hour;
        logic [5:0]  minute;
        logic [5:0]  second;
    } time_of_day_t;

    typedef struct packed {
        logic hourly;
        logic second;
        logic day;
        logic alarm;
        logic minute;
        logic stopwatch;
    } event_bits_t;

endpackage

// file: rtl/rtc_events_stopwatch_prescaler.sv
// real-time clock with events, alarm, stopwatch and prescaler
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ns
module rtc_events_stopwatch_prescaler
    import rtc_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    // reference clock pin, sampled
    input  wire logic        ref_clk_i,
    // avalon-mm slave
    input  wire logic [11:0] address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [3:0]  byteenable_i,
    input  wire logic [31:0] writedata_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    // outputs
    output logic             irq_o,
    output logic             sample_tick_o
);

    // ****************************************
    // state
    // ****************************************
    logic [2:0]   ref_sync;
    logic         ref_rise;
    logic [31:0]  prescale_divisor;
    logic [31:0]  sec_count;
    logic [22:0]  smp_count;
    logic         tick;
    logic         module_enable;
    time_of_day_t time_of_day;
    time_of_day_t alarm;
    event_bits_t  event_status;
    event_bits_t  event_enable;
    logic [5:0]   countdown_value;
    logic         done;
    logic         wr;
    logic         soft_reset;
    logic         sec_wrap;
    logic         min_wrap;
    logic         hour_wrap;
    logic         minute_tick;
    logic         alarm_hit;
    logic         alarm_prev;
    logic         sw_pending;
    logic         tod_write;
    logic [5:0]   second_count;
    logic [5:0]   minute_count;
    logic [4:0]   hour_count;
    logic [15:0]  day_count;
    logic [5:0]   alarm_second;
    logic [5:0]   alarm_minute;
    logic [4:0]   alarm_hour;
    logic [15:0]  alarm_day_value;
    event_bits_t  ev_set;
    event_bits_t  ev_clr;
    logic [31:0]  next_readdata;

    // ****************************************
    // bus handshake
    // ****************************************
    // one wait cycle per access, answer on second edge
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i || done)
            done <= 1'b0;
        else
            done <= (read_i || write_i);
    end

    assign waitrequest_o = (read_i || write_i) && !done;
    assign wr            = write_i && done;
    assign soft_reset    = wr && address_i == OFS_CONTROL
                           && byteenable_i[0]
                           && writedata_i[BIT_SOFT_RESET];

    // ****************************************
    // prescaler
    // ****************************************
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
            ref_sync <= 3'h0;
        else
            ref_sync <= {ref_sync[1:0], ref_clk_i};
    end

    assign ref_rise = ref_sync[1] && !ref_sync[2];

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i || soft_reset)
        begin
            sec_count <= 32'h0;
            tick      <= 1'b0;
        end
        else if (prescale_divisor == 32'h0)
        begin
            sec_count <= 32'h0;
            tick      <= 1'b0;
        end
        else if (ref_rise)
        begin
            tick <= (sec_count + 32'h1 >= prescale_divisor);
            if (sec_count + 32'h1 >= prescale_divisor)
                sec_count <= 32'h0;
            else
                sec_count <= sec_count + 32'h1;
        end
        else
            tick <= 1'b0;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i || soft_reset)
        begin
            smp_count     <= 23'h0;
            sample_tick_o <= 1'b0;
        end
        else if (prescale_divisor[31:SAMPLE_SHIFT] == 23'h0)
        begin
            smp_count     <= 23'h0;
            sample_tick_o <= 1'b0;
        end
        else if (ref_rise)
        begin
            sample_tick_o <= (smp_count + 23'h1
                              >= prescale_divisor[31:SAMPLE_SHIFT]);
            if (smp_count + 23'h1 >= prescale_divisor[31:SAMPLE_SHIFT])
                smp_count <= 23'h0;
            else
                smp_count <= smp_count + 23'h1;
        end
        else
            sample_tick_o <= 1'b0;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i || soft_reset)
            prescale_divisor <= DIVISOR_RST;
        else if (wr && address_i == OFS_DIV_UPPER)
            prescale_divisor[31:16] <= writedata_i[15:0];
        else if (wr && address_i == OFS_DIV_LOWER)
            prescale_divisor[15:0] <= writedata_i[15:0];
    end

    // ****************************************
    // time of day counters
    // ****************************************
    assign sec_wrap    = tick && module_enable;
    assign min_wrap    = sec_wrap && time_of_day.second == LAST_SECOND;
    assign hour_wrap   = min_wrap && time_of_day.minute == LAST_MINUTE;
    assign minute_tick = min_wrap;

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
            module_enable <= ENABLE_RST;
        else if (wr && address_i == OFS_CONTROL && byteenable_i[0])
            module_enable <= writedata_i[BIT_ENABLE];
    end

    // a write to any counter register overrides a simultaneous tick
    assign tod_write = wr && (address_i == OFS_HOUR_MINUTE
                              || address_i == OFS_SECONDS
                              || address_i == OFS_DAY_COUNTER);

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i || soft_reset)
            second_count <= 6'h0;
        else if (wr && address_i == OFS_SECONDS)
            second_count <= writedata_i[5:0];
        else if (sec_wrap && !tod_write)
            second_count <= (second_count == LAST_SECOND) ? 6'h0
                            : second_count + 6'h1;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i || soft_reset)
            minute_count <= 6'h0;
        else if (wr && address_i == OFS_HOUR_MINUTE)
            minute_count <= writedata_i[5:0];
        else if (min_wrap && !tod_write)
            minute_count <= (minute_count == LAST_MINUTE) ? 6'h0
                            : minute_count + 6'h1;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i || soft_reset)
            hour_count <= 5'h0;
        else if (wr && address_i == OFS_HOUR_MINUTE)
            hour_count <= writedata_i[HOURS_LSB +: 5];
        else if (hour_wrap && !tod_write)
            hour_count <= (hour_count == LAST_HOUR) ? 5'h0
                          : hour_count + 5'h1;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i || soft_reset)
            day_count <= 16'h0;
        else if (wr && address_i == OFS_DAY_COUNTER)
            day_count <= writedata_i[15:0];
        else if (hour_wrap && hour_count == LAST_HOUR && !tod_write)
            day_count <= day_count + 16'h1;
    end

    assign time_of_day = {day_count, hour_count, minute_count, second_count};

    // ****************************************
    // alarm registers
    // ****************************************
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i || soft_reset)
            alarm_second <= 6'h0;
        else if (wr && address_i == OFS_ALARM_SEC)
            alarm_second <= writedata_i[5:0];
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i || soft_reset)
            alarm_minute <= 6'h0;
        else if (wr && address_i == OFS_ALARM_HM)
            alarm_minute <= writedata_i[5:0];
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i || soft_reset)
            alarm_hour <= 5'h0;
        else if (wr && address_i == OFS_ALARM_HM)
            alarm_hour <= writedata_i[HOURS_LSB +: 5];
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i || soft_reset)
            alarm_day_value <= 16'h0;
        else if (wr && address_i == OFS_DAY_ALARM)
            alarm_day_value <= writedata_i[15:0];
    end

    assign alarm = {alarm_day_value, alarm_hour, alarm_minute, alarm_second};

    assign alarm_hit = (time_of_day == alarm);

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i || soft_reset)
            alarm_prev <= 1'b1;
        else
            alarm_prev <= alarm_hit;
    end

    // ****************************************
    // stopwatch
    // ****************************************
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i || soft_reset)
            countdown_value <= STOPWATCH_RST;
        else if (wr && address_i == OFS_STOPWATCH)
            countdown_value <= writedata_i[5:0];
        else if (minute_tick && countdown_value != STOPWATCH_DONE)
            countdown_value <= countdown_value - 6'h1;
    end

    // enable raised while already at -1 posts at next minute tick
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i || soft_reset)
            sw_pending <= 1'b0;
        else if (minute_tick)
            sw_pending <= 1'b0;
        else if (wr && address_i == OFS_EVENT_ENABLE
                 && writedata_i[BIT_STOPWATCH] && !event_enable.stopwatch
                 && countdown_value == STOPWATCH_DONE)
            sw_pending <= 1'b1;
    end

    // ****************************************
    // event status and enable
    // ****************************************
    always_comb
    begin
        ev_set           = '0;
        ev_set.second    = sec_wrap;
        ev_set.minute    = min_wrap;
        ev_set.hourly    = hour_wrap;
        ev_set.day       = hour_wrap && time_of_day.hour == LAST_HOUR;
        ev_set.alarm     = alarm_hit && !alarm_prev;
        ev_set.stopwatch = minute_tick
                           && (countdown_value == 6'h0 || sw_pending);
        ev_clr           = '0;
        if (wr && address_i == OFS_EVENT_STATUS)
            ev_clr = writedata_i[5:0];
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i || soft_reset)
            event_status <= '0;
        else
            event_status <= (event_status & ~ev_clr) | ev_set;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i || soft_reset)
            event_enable <= '0;
        else if (wr && address_i == OFS_EVENT_ENABLE)
            event_enable <= writedata_i[5:0];
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(event_status & event_enable);
    end

    // ****************************************
    // read mux
    // ****************************************
    always_comb
    begin
        next_readdata = 32'h0;
        if (address_i == OFS_HOUR_MINUTE)
            next_readdata = {19'h0, time_of_day.hour, 2'h0, time_of_day.minute};
        else if (address_i == OFS_SECONDS)
            next_readdata = {26'h0, time_of_day.second};
        else if (address_i == OFS_ALARM_HM)
            next_readdata = {19'h0, alarm.hour, 2'h0, alarm.minute};
        else if (address_i == OFS_ALARM_SEC)
            next_readdata = {26'h0, alarm.second};
        else if (address_i == OFS_CONTROL)
            next_readdata = {24'h0, module_enable, 7'h0};
        else if (address_i == OFS_EVENT_STATUS)
            next_readdata = {26'h0, event_status};
        else if (address_i == OFS_EVENT_ENABLE)
            next_readdata = {26'h0, event_enable};
        else if (address_i == OFS_STOPWATCH)
            next_readdata = {26'h0, countdown_value};
        else if (address_i == OFS_DAY_COUNTER)
            next_readdata = {16'h0, time_of_day.day};
        else if (address_i == OFS_DAY_ALARM)
            next_readdata = {16'h0, alarm.day};
        else if (address_i == OFS_DIV_UPPER)
            next_readdata = {16'h0, prescale_divisor[31:16]};
        else if (address_i == OFS_DIV_LOWER)
            next_readdata = {16'h0, prescale_divisor[15:0]};
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
            readdata_o <= 32'h0;
        else if (read_i && !done)
            readdata_o <= next_readdata;
    end

endmodule // rtc_events_stopwatch_prescaler

// file: bench/rtc_chk.sv
// checker for bus timing, field layout and interrupt behaviour
`timescale 1ns/1ns
module rtc_chk
    import rtc_pkg::*;
(
    // clock and reset
    input wire logic        core_clk_i,
    input wire logic        resetn_i,
    // inputs of the block
    input wire logic        ref_clk_i,
    input wire logic [11:0] address_i,
    input wire logic        read_i,
    input wire logic        write_i,
    input wire logic [3:0]  byteenable_i,
    input wire logic [31:0] writedata_i,
    // outputs of the block
    input wire logic [31:0] readdata_o,
    input wire logic        waitrequest_o,
    input wire logic        irq_o,
    input wire logic        sample_tick_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    // ****************************************
    // assertions
    // ****************************************
    wait_first_a: assert property (
        (read_i || write_i) && !$past(read_i || write_i) |-> waitrequest_o)
        else $error("new request got no wait cycle");
    wait_bound_a: assert property (
        (read_i || write_i) |-> ##[0:1] !waitrequest_o)
        else $error("request not answered in time");
    sw_upper_a: assert property (
        read_i && !waitrequest_o && address_i == OFS_STOPWATCH
        |-> readdata_o[31:6] == 26'h0) else $error("stopwatch upper bits");
    en_upper_a: assert property (
        read_i && !waitrequest_o && address_i == OFS_EVENT_ENABLE
        |-> readdata_o[31:6] == 26'h0) else $error("enable upper bits");
    day_upper_a: assert property (
        read_i && !waitrequest_o && address_i == OFS_DAY_COUNTER
        |-> readdata_o[31:16] == 16'h0) else $error("day upper bits");
    stat_upper_a: assert property (
        read_i && !waitrequest_o && address_i == OFS_EVENT_STATUS
        |-> readdata_o[31:6] == 26'h0) else $error("status upper bits");
    irq_mask_a: assert property (
        write_i && !waitrequest_o && address_i == OFS_EVENT_ENABLE
        && writedata_i[5:0] == 6'h0 |=> ##1 !irq_o)
        else $error("irq high with all enables clear");
    sample_pulse_a: assert property (
        sample_tick_o |=> !sample_tick_o) else $error("sample tick too long");
endmodule // rtc_chk

bind rtc_events_stopwatch_prescaler rtc_chk i_chk (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .ref_clk_i(ref_clk_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .byteenable_i(byteenable_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .irq_o(irq_o), .sample_tick_o(sample_tick_o)
);

// file: bench/rtc_events_stopwatch_prescaler_tb.sv
// testbench of the real-time clock block
`timescale 1ns/1ns
module rtc_events_stopwatch_prescaler_tb
    import rtc_pkg::*;
;
    logic        core_clk_i    = 1'b0;
    logic        resetn_i      = 1'b0;
    logic        ref_clk_i     = 1'b0;
    logic        read_i        = 1'b0;
    logic        write_i       = 1'b0;
    logic [11:0] address_i     = 12'h0;
    logic [3:0]  byteenable_i  = 4'hF;
    logic [31:0] writedata_i   = 32'h0;
    logic [31:0] readdata_o;
    logic        waitrequest_o;
    logic        irq_o;
    logic        sample_tick_o;
    logic [1:0]  rdiv          = 2'h0;
    logic [31:0] q;
    int          num_errors    = 0;
    int          checked       = 0;
    int          waited        = 0;

    rtc_events_stopwatch_prescaler i_dut (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i), .ref_clk_i(ref_clk_i),
        .address_i(address_i), .read_i(read_i), .write_i(write_i),
        .byteenable_i(byteenable_i), .writedata_i(writedata_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .irq_o(irq_o), .sample_tick_o(sample_tick_o)
    );

    initial forever #50 core_clk_i = ~core_clk_i;

    // reference clock: one rising edge every four cycles
    always @(posedge core_clk_i)
    begin
        rdiv <= rdiv + 2'h1;
        ref_clk_i <= rdiv[1];
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic end_sim();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk_i);
        address_i <= a;
        writedata_i <= d;
        write_i <= wr;
        read_i <= !wr;
        do
        begin
            @(posedge core_clk_i);
            n++;
        end
        while (waitrequest_o !== 1'b0 && n < 40);
        q = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
        if (n >= 40)
            cmp("waitrequest_o", 32'h0, 32'h1);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input string n);
        bus(1'b0, a, 32'h0);
        cmp(n, e, q);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq_o !== 1'b1 && n < 300)
        begin
            @(posedge core_clk_i);
            n++;
        end
        cmp("irq_o", 32'h1, {31'h0, irq_o});
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        repeat (6) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        rd(OFS_EVENT_ENABLE, 32'h0, "event_enable");
        rd(OFS_STOPWATCH, {26'h0, STOPWATCH_RST}, "stopwatch");
        rd(OFS_DIV_LOWER, DIVISOR_RST, "divisor_lower");
        wr(OFS_DIV_UPPER, 32'h0000_ABCD);
        rd(OFS_DIV_UPPER, 32'h0000_ABCD, "divisor_upper");
        wr(OFS_DIV_UPPER, 32'h0);
        wr(12'h3F0, 32'hFFFF_FFFF);
        rd(12'h3F0, 32'h0, "unmapped");
        $display("test reset values done");
        wr(OFS_DIV_LOWER, 32'h0);
        wr(OFS_HOUR_MINUTE, 32'h0000_173B);
        wr(OFS_SECONDS, 32'h3B);
        wr(OFS_DAY_COUNTER, 32'hFFFF);
        wr(OFS_STOPWATCH, 32'h0);
        wr(OFS_ALARM_HM, 32'h0);
        wr(OFS_ALARM_SEC, 32'h0);
        wr(OFS_DAY_ALARM, 32'h0);
        wr(OFS_EVENT_ENABLE, 32'h10);
        wr(OFS_EVENT_STATUS, 32'h3F);
        rd(OFS_EVENT_STATUS, 32'h0, "status idle");
        wr(OFS_DIV_LOWER, 32'h4);
        wait_irq();
        wr(OFS_DIV_LOWER, 32'h0);
        rd(OFS_EVENT_STATUS, 32'h3F, "status rollover");
        rd(OFS_SECONDS, 32'h0, "seconds");
        rd(OFS_HOUR_MINUTE, 32'h0, "hour_minute");
        rd(OFS_DAY_COUNTER, 32'h0, "day_counter");
        rd(OFS_STOPWATCH, 32'h3F, "stopwatch");
        $display("test rollover done");
        wr(OFS_EVENT_STATUS, 32'h0);
        rd(OFS_EVENT_STATUS, 32'h3F, "status w0");
        wr(OFS_EVENT_STATUS, 32'h10);
        rd(OFS_EVENT_STATUS, 32'h2F, "status w1c");
        cmp("irq_o", 32'h0, {31'h0, irq_o});
        wr(OFS_EVENT_ENABLE, 32'h08);
        rd(OFS_EVENT_ENABLE, 32'h08, "event_enable");
        cmp("irq_o", 32'h1, {31'h0, irq_o});
        wr(OFS_EVENT_ENABLE, 32'h0);
        wr(OFS_EVENT_STATUS, 32'h3F);
        $display("test status clear done");
        wr(OFS_SECONDS, 32'h3B);
        wr(OFS_EVENT_ENABLE, 32'h03);
        wr(OFS_DIV_LOWER, 32'h4);
        wait_irq();
        wr(OFS_DIV_LOWER, 32'h0);
        rd(OFS_EVENT_STATUS, 32'h13, "status minute");
        rd(OFS_STOPWATCH, 32'h3F, "stopwatch hold");
        rd(OFS_HOUR_MINUTE, 32'h1, "hour_minute");
        $display("test stopwatch done");
        wr(OFS_EVENT_ENABLE, 32'h0);
        wr(OFS_EVENT_STATUS, 32'h3F);
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_DIV_LOWER, 32'h4);
        repeat (80) @(posedge core_clk_i);
        rd(OFS_EVENT_STATUS, 32'h0, "status frozen");
        rd(OFS_SECONDS, 32'h0, "seconds frozen");
        wr(OFS_DAY_COUNTER, 32'h1234);
        rd(OFS_DAY_COUNTER, 32'h1234, "day_counter");
        wr(OFS_CONTROL, 32'h81);
        bus(1'b0, OFS_CONTROL, 32'h0);
        cmp("control enable", 32'h80, q & 32'h80);
        rd(OFS_DAY_COUNTER, 32'h0, "day soft reset");
        rd(OFS_DIV_LOWER, DIVISOR_RST, "divisor soft reset");
        rd(OFS_STOPWATCH, 32'h3F, "stopwatch soft reset");
        $display("test enable and soft reset done");
        while (sample_tick_o !== 1'b1 && waited < 400)
        begin
            @(posedge core_clk_i);
            waited++;
        end
        cmp("sample_tick_o", 32'h1, {31'h0, sample_tick_o});
        cmp("sample period", 32'h1, {31'h0, waited >= 200});
        $display("test sample clock done");
        end_sim();
    end

    // watchdog against a hung test: fails the run after 20000 cycles
    initial
    begin
        repeat (20000) @(posedge core_clk_i);
        num_errors++;
        end_sim();
    end
endmodule // rtc_events_stopwatch_prescaler_tb
